/* File: dv/io_port_monitor.sv */
// Port checker for the programmable I/O port block.
// Assumes the defs header is on the include path; bound below.
`timescale 1ns/100ps
`include "gpio_port_defs.svh"

module io_port_monitor (
   // Clock, reset and bus
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [5:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   // Pins and overrides
   input wire logic [7:0]  grp1_pin_o,
   input wire logic [7:0]  grp1_pin_oe_n_o,
   input wire logic [7:0]  grp1_pullup_o,
   input wire logic [7:0]  grp3_pin_oe_n_o,
   input wire logic [7:0]  grp3_pullup_o,
   input wire logic [7:0]  grp4_pin_oe_n_o,
   input wire logic [7:0]  periph1_oe_i,
   input wire logic [7:0]  periph1_out_i,
   // Share state
   input wire logic        adc_used_o,
   input wire logic        osc_used_o
);
   // ----
   // Properties
   // ----
   default clocking mon_cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // A fresh request, then a group-one write being acknowledged
   sequence req_s;
      $rose(cyc_i & stb_i);
   endsequence
   sequence wr1_s(logic [5:0] ofs);
      ack_o && we_i && sel_i[0] && adr_i == ofs && periph1_oe_i == 8'h00;
   endsequence

   ack_time_a: assert property (req_s |=> ack_o ^ err_o)
      else $error("no single answer one cycle after request");
   ack_pulse_a: assert property (ack_o |=> !ack_o && !err_o)
      else $error("answer held longer than one cycle");
   rst_state_a: assert property ($past(sys_rst_i) |->
      &grp1_pin_oe_n_o && &grp3_pin_oe_n_o && adc_used_o && osc_used_o)
      else $error("pins driven right after reset");
   no_drive_a: assert property (&grp3_pin_oe_n_o[2:0] &&
      grp3_pin_oe_n_o[6] && (grp4_pin_oe_n_o | 8'h20) == 8'hff)
      else $error("pin without output driver is driven");
   dir_oe_a: assert property (wr1_s(`OFS_DIR1) |=>
      grp1_pin_oe_n_o == ~$past(dat_i[7:0]))
      else $error("direction write not reflected on enables");
   latch_pin_a: assert property (wr1_s(`OFS_DATA1) |=>
      ((grp1_pin_o ^ $past(dat_i[7:0])) & ~grp1_pin_oe_n_o) == 8'h00)
      else $error("output pin does not show latch");
   periph_drv_a: assert property (periph1_oe_i != 8'h00 |=>
      (grp1_pin_oe_n_o & $past(periph1_oe_i)) == 8'h00 &&
      ((grp1_pin_o ^ $past(periph1_out_i)) & $past(periph1_oe_i)) == 8'h00)
      else $error("peripheral output not driven");
   pull_drv_a: assert property (
      (grp1_pullup_o & ~grp1_pin_oe_n_o) == 8'h00 &&
      (grp3_pullup_o & ~grp3_pin_oe_n_o) == 8'h00)
      else $error("pull-up on a driven pin");
   dir_read_a: assert property (ack_o && !we_i &&
      (adr_i == `OFS_DIR3 || adr_i == `OFS_DIR4) |-> (dat_o &
      (adr_i == `OFS_DIR3 ? 32'hffff_ff47 : 32'hffff_ffdf)) == 32'h0)
      else $error("unimplemented direction bit reads one");
endmodule

bind programmable_io_port io_port_monitor i_io_port_monitor (
   .clk_i, .sys_rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
   .dat_o, .ack_o, .err_o, .grp1_pin_o, .grp1_pin_oe_n_o, .grp1_pullup_o,
   .grp3_pin_oe_n_o, .grp3_pullup_o, .grp4_pin_oe_n_o, .periph1_oe_i,
   .periph1_out_i, .adc_used_o, .osc_used_o);

/* File: dv/pin_env.sv */
// Board-side model of one 8-bit group of pins.
// Assumes the bench sets the external levels on clk_i edges.
`timescale 1ns/100ps

module pin_env (
   // Clock
   input  wire logic       clk_i,
   // Block side
   input  wire logic [7:0] drv_i,
   input  wire logic [7:0] oe_n_i,
   input  wire logic [7:0] pullup_i,
   // Bench side
   input  wire logic [7:0] ext_val_i,
   input  wire logic [7:0] ext_en_i,
   output logic      [7:0] pin_lvl_o
);
   logic [7:0] last_ff = 8'h00;

   // Floating wires flip each cycle so a stale level never passes
   always_ff @(posedge clk_i) begin
      last_ff <= pin_lvl_o;
   end

   // Block driver wins, then outside source, then pull-up
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         if (!oe_n_i[k]) pin_lvl_o[k] = drv_i[k];
         else if (ext_en_i[k]) pin_lvl_o[k] = ext_val_i[k];
         else if (pullup_i[k]) pin_lvl_o[k] = 1'b1;
         else pin_lvl_o[k] = ~last_ff[k];
      end
   end
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the programmable I/O port block.
// Assumes the defs header, checker and pin_env are compiled first.
`timescale 1ns/100ps
`include "gpio_port_defs.svh"

module tb;
   // ----
   // Wiring
   // ----
   logic        clk_i = 1'b0, sys_rst_i = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [5:0]  adr_i = 6'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic        ack_o, err_o, rerr, adc_used_o, osc_used_o;
   logic [7:0]  grp1_pin_i, grp1_pin_o, grp1_pin_oe_n_o, grp1_pullup_o;
   logic [7:0]  grp3_pin_i, grp3_pin_o, grp3_pin_oe_n_o, grp3_pullup_o;
   logic [7:0]  grp4_pin_i, grp4_pin_o, grp4_pin_oe_n_o, grp4_pullup_o;
   logic [7:0]  periph1_oe_i = 8'h00, periph1_out_i = 8'h00;
   logic [7:0]  ext1_val = 8'h00, ext1_en = 8'h00;
   logic [7:0]  ext3_val = 8'h00, ext3_en = 8'h00;
   logic [7:0]  ext4_val = 8'h00, ext4_en = 8'h00;
   int          fail_count = 0, n_tests = 0, cycles = 0;

   programmable_io_port i_programmable_io_port (
      .clk_i, .sys_rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .err_o, .grp1_pin_i, .grp1_pin_o, .grp1_pin_oe_n_o,
      .grp1_pullup_o, .grp3_pin_i, .grp3_pin_o, .grp3_pin_oe_n_o,
      .grp3_pullup_o, .grp4_pin_i, .grp4_pin_o, .grp4_pin_oe_n_o,
      .grp4_pullup_o, .periph1_oe_i, .periph1_out_i,
      .periph3_oe_i(8'h00), .periph3_out_i(8'h00), .periph4_oe_i(8'h00),
      .periph4_out_i(8'h00), .adc_used_o, .osc_used_o);
   pin_env i_pin_env1 (.clk_i, .drv_i(grp1_pin_o), .oe_n_i(grp1_pin_oe_n_o),
      .pullup_i(grp1_pullup_o), .ext_val_i(ext1_val), .ext_en_i(ext1_en),
      .pin_lvl_o(grp1_pin_i));
   pin_env i_pin_env3 (.clk_i, .drv_i(grp3_pin_o), .oe_n_i(grp3_pin_oe_n_o),
      .pullup_i(grp3_pullup_o), .ext_val_i(ext3_val), .ext_en_i(ext3_en),
      .pin_lvl_o(grp3_pin_i));
   pin_env i_pin_env4 (.clk_i, .drv_i(grp4_pin_o), .oe_n_i(grp4_pin_oe_n_o),
      .pullup_i(grp4_pullup_o), .ext_val_i(ext4_val), .ext_en_i(ext4_en),
      .pin_lvl_o(grp4_pin_i));

   // 100 MHz clock; hang guard far above the 130 or so cycles needed
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         wrap_up();
      end
   end

   // ----
   // Shared tasks
   // ----
   task automatic wrap_up();
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask

   // Classic cycle: hold everything until ack or err is sampled
   task automatic wb(input logic w, input logic [5:0] a,
                     input logic [7:0] d, input logic [3:0] s);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
      rd = dat_o;
      rerr = err_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'hf);
   endtask

   task automatic rdc(input string nm, input logic [5:0] a,
                      input logic [7:0] e);
      wb(1'b0, a, 8'h00, 4'hf);
      chk(nm, {24'h0, e}, rd);
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_reset();
      @(negedge clk_i);
      chk("oe1", 8'hff, grp1_pin_oe_n_o);
      chk("share", 2'h3, {adc_used_o, osc_used_o});
      @(posedge clk_i);
      rdc("dir1", `OFS_DIR1, 8'h00);
      rdc("dir3", `OFS_DIR3, 8'h00);
   endtask

   task automatic t_dir();
      wr(`OFS_DIR3, 8'hff);
      rdc("dir3", `OFS_DIR3, 8'hb8);
      wr(`OFS_DIR4, 8'hff);
      rdc("dir4", `OFS_DIR4, 8'h20);
      wr(`OFS_DATA3, 8'hff);
      wr(`OFS_DATA4, 8'hff);
      @(negedge clk_i);
      chk("oe3", 8'h47, grp3_pin_oe_n_o);
      chk("oe4", 8'hdf, grp4_pin_oe_n_o);
      chk("pin3", 8'hb8, grp3_pin_o);
      chk("pin4", 8'h20, grp4_pin_o);
      @(posedge clk_i);
      wr(`OFS_DIR3, 8'h00);
      wr(`OFS_DIR4, 8'h00);
      ext3_en <= 8'hff;
      ext3_val <= 8'h6b;
      rdc("data3", `OFS_DATA3, 8'h28);
   endtask

   task automatic t_data();
      ext1_en <= 8'hf0;
      ext1_val <= 8'h3c;
      wr(`OFS_DIR1, 8'h0f);
      wr(`OFS_DATA1, 8'h96);
      rdc("data1", `OFS_DATA1, 8'h36);
      @(negedge clk_i);
      chk("pin1", 8'h06, grp1_pin_o & 8'h0f);
      @(posedge clk_i);
      ext1_en <= 8'h00;
      wr(`OFS_DIR1, 8'hff);
      @(negedge clk_i);
      chk("pin1", 8'h96, grp1_pin_o);
      @(posedge clk_i);
      rdc("data1", `OFS_DATA1, 8'h96);
   endtask

   task automatic t_pull();
      wr(`OFS_DIR1, 8'h0f);
      wr(`OFS_PULLUP_A, 8'h03);
      wr(`OFS_PULLUP_B, 8'h07);
      @(negedge clk_i);
      chk("pu1", 8'hf0, grp1_pullup_o);
      chk("pu3", 8'hb8, grp3_pullup_o);
      chk("pu4", 8'h20, grp4_pullup_o);
      @(posedge clk_i);
      rdc("data1", `OFS_DATA1, 8'hf6);
      wr(`OFS_PULLUP_A, 8'h00);
      wr(`OFS_PULLUP_B, 8'h00);
      wr(`OFS_DIR1, 8'h00);
   endtask

   task automatic t_periph();
      periph1_oe_i <= 8'h81;
      periph1_out_i <= 8'h01;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("oe1", 8'h7e, grp1_pin_oe_n_o);
      chk("pin1", 8'h01, grp1_pin_o & 8'h81);
      @(posedge clk_i);
      periph1_oe_i <= 8'h00;
      ext1_en <= 8'hff;
      ext1_val <= 8'h5a;
      repeat (2) @(posedge clk_i);
      rdc("pin_in", `OFS_DATA1, 8'h5a);
      ext1_en <= 8'h00;
   endtask

   task automatic t_inonly();
      ext4_en <= 8'hff;
      ext4_val <= 8'he4;
      wr(`OFS_SHARE_CTL, 8'h00);
      rdc("in4", `OFS_DATA4, 8'he4);
      wr(`OFS_SHARE_CTL, 8'h01);
      chk("used", 2'h2, {adc_used_o, osc_used_o});
      rdc("in4", `OFS_DATA4, 8'he0);
      wr(`OFS_SHARE_CTL, 8'h02);
      rdc("in4", `OFS_DATA4, 8'h24);
      wr(`OFS_SHARE_CTL, 8'h03);
      rdc("in4", `OFS_DATA4, 8'h20);
   endtask

   task automatic t_bus();
      wb(1'b1, `OFS_DIR1, 8'hff, 4'he);
      rdc("dir1", `OFS_DIR1, 8'h00);
      wb(1'b1, 6'h3c, 8'hff, 4'hf);
      chk("err", 1'b1, rerr);
      rdc("dir1", `OFS_DIR1, 8'h00);
   endtask

   initial begin
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_dir();
      t_data();
      t_pull();
      t_periph();
      t_inonly();
      t_bus();
      wrap_up();
   end
endmodule

/* File: hdl/port_group.sv */
// One 8-bit port group: latch, direction, pin drive and read mux.
// Assumes pins are synchronous to clk_i; writes come as strobes.
`timescale 1ns/100ps
`include "gpio_port_defs.svh"

module port_group #(
   parameter logic [7:0] IMPL_MASK = 8'hff
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Register writes
   input  wire logic       data_we_i,
   input  wire logic       dir_we_i,
   input  wire logic [7:0] wdata_i,
   // Peripheral override
   input  wire logic [7:0] periph_oe_i,
   input  wire logic [7:0] periph_out_i,
   // Pull-up selection per bit
   input  wire logic [7:0] pu_sel_i,
   // Pins
   input  wire logic [7:0] pin_i,
   output logic      [7:0] pin_o,
   output logic      [7:0] pin_oe_n_o,
   output logic      [7:0] pullup_o,
   // Read value and state
   output logic      [7:0] data_rd_o,
   output logic      [7:0] dir_o
);

   logic [7:0] latch_ff;
   logic [7:0] dir_ff;

   // --------------------------------------------------------------
   // Output latch: written whatever the direction
   // --------------------------------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         latch_ff <= `RST_DATA;
      end else if (data_we_i) begin
         latch_ff <= wdata_i & IMPL_MASK;
      end
   end

   // --------------------------------------------------------------
   // Direction bits; absent pins hold no storage
   // --------------------------------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dir_ff <= `RST_DIR;
      end else if (dir_we_i) begin
         dir_ff <= wdata_i & IMPL_MASK;
      end
   end

   assign dir_o = dir_ff & IMPL_MASK;

   // --------------------------------------------------------------
   // Per-bit pin drive and read path
   // --------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bit
         if (IMPL_MASK[b]) begin : g_pin
            logic drive;
            // Peripheral output wins over the direction bit
            assign drive = periph_oe_i[b] | dir_ff[b];
            assign pin_o[b] = periph_oe_i[b] ? periph_out_i[b]
                                             : latch_ff[b];
            assign pin_oe_n_o[b] = ~drive;
            // Pull-up only while nothing drives the pin
            assign pullup_o[b] = pu_sel_i[b] & ~drive;
            // Input mode reads pin, output mode the latch
            assign data_rd_o[b] = dir_ff[b] ? latch_ff[b]
                                            : pin_i[b];
         end else begin : g_none
            assign pin_o[b]      = 1'b0;
            assign pin_oe_n_o[b] = 1'b1;
            assign pullup_o[b]   = 1'b0;
            assign data_rd_o[b]  = 1'b0;
         end
      end
   endgenerate

endmodule

/* File: hdl/programmable_io_port.sv */
// Programmable I/O port block with a classic Wishbone register slave.
// Assumes pins and peripheral signals are synchronous to clk_i.
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "gpio_port_defs.svh"

module programmable_io_port (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [5:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             err_o,
   // Group one pins
   input  wire logic [7:0]  grp1_pin_i,
   output logic      [7:0]  grp1_pin_o,
   output logic      [7:0]  grp1_pin_oe_n_o,
   output logic      [7:0]  grp1_pullup_o,
   // Group three pins
   input  wire logic [7:0]  grp3_pin_i,
   output logic      [7:0]  grp3_pin_o,
   output logic      [7:0]  grp3_pin_oe_n_o,
   output logic      [7:0]  grp3_pullup_o,
   // Group four bidirectional pin and input-only pins
   input  wire logic [7:0]  grp4_pin_i,
   output logic      [7:0]  grp4_pin_o,
   output logic      [7:0]  grp4_pin_oe_n_o,
   output logic      [7:0]  grp4_pullup_o,
   // Peripheral overrides, per group
   input  wire logic [7:0]  periph1_oe_i,
   input  wire logic [7:0]  periph1_out_i,
   input  wire logic [7:0]  periph3_oe_i,
   input  wire logic [7:0]  periph3_out_i,
   input  wire logic [7:0]  periph4_oe_i,
   input  wire logic [7:0]  periph4_out_i,
   // Shared-pin usage state
   output logic             adc_used_o,
   output logic             osc_used_o
);

   // --------------------------------------------------------------
   // Bus decode
   // --------------------------------------------------------------
   gpio_port_pkg::bus_state_t bus_ff;
   logic        req;
   logic        wr_go;
   logic        hit;
   logic        lane0;
   logic [31:0] nxt_rdata;

   assign req   = cyc_i & stb_i & (bus_ff == gpio_port_pkg::BUS_IDLE);
   assign lane0 = sel_i[0];
   // Only byte lane 0 carries data; upper lanes ignored
   assign wr_go = req & we_i & hit & lane0;

   // --------------------------------------------------------------
   // Per-register write strobes
   // --------------------------------------------------------------
   logic wr_data1;
   logic wr_data3;
   logic wr_data4;
   logic wr_dir1;
   logic wr_dir3;
   logic wr_dir4;
   logic wr_pu_a;
   logic wr_pu_b;
   logic wr_share;

   // One compare per register, shared by the groups and control bits
   assign wr_data1 = wr_go & (adr_i == `OFS_DATA1);
   assign wr_data3 = wr_go & (adr_i == `OFS_DATA3);
   assign wr_data4 = wr_go & (adr_i == `OFS_DATA4);
   assign wr_dir1  = wr_go & (adr_i == `OFS_DIR1);
   assign wr_dir3  = wr_go & (adr_i == `OFS_DIR3);
   assign wr_dir4  = wr_go & (adr_i == `OFS_DIR4);
   assign wr_pu_a  = wr_go & (adr_i == `OFS_PULLUP_A);
   assign wr_pu_b  = wr_go & (adr_i == `OFS_PULLUP_B);
   assign wr_share = wr_go & (adr_i == `OFS_SHARE_CTL);

   // --------------------------------------------------------------
   // Control registers
   // --------------------------------------------------------------
   logic [1:0] pu_a_ff;
   logic [2:0] pu_b_ff;
   logic [1:0] share_ff;

   // Pull-up selection, the two halves of group one
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pu_a_ff <= 2'(`RST_PULLUP);
      end else if (wr_pu_a) begin
         pu_a_ff <= dat_i[1:0];
      end
   end

   // Pull-up selection, groups three and four
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pu_b_ff <= `RST_PULLUP;
      end else if (wr_pu_b) begin
         pu_b_ff <= dat_i[2:0];
      end
   end

   // Oscillator and converter use; reset assumes both in use
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         share_ff <= `RST_SHARE;
      end else if (wr_share) begin
         share_ff <= dat_i[1:0];
      end
   end

   // --------------------------------------------------------------
   // Pull-up fan-out: four bits, three plus one, single
   // --------------------------------------------------------------
   logic [7:0] pu1;
   logic [7:0] pu3;
   logic [7:0] pu4;

   assign pu1 = {{4{pu_a_ff[`PU_G1_HI]}},
                 {4{pu_a_ff[`PU_G1_LO]}}};
   assign pu3 = {pu_b_ff[`PU_G3_7], 1'b0,
                 {3{pu_b_ff[`PU_G3_345]}}, 3'h0};
   assign pu4 = {2'h0, pu_b_ff[`PU_G4_5], 5'h00};

   // --------------------------------------------------------------
   // Port groups
   // --------------------------------------------------------------
   // Read values and direction state per group
   logic [7:0] rd1;
   logic [7:0] rd3;
   logic [7:0] rd4;
   logic [7:0] dir1;
   logic [7:0] dir3;
   logic [7:0] dir4;
   // Unregistered pin sources, flopped before leaving the block
   logic [7:0] p1_o;
   logic [7:0] p1_oen;
   logic [7:0] p1_pu;
   logic [7:0] p3_o;
   logic [7:0] p3_oen;
   logic [7:0] p3_pu;
   logic [7:0] p4_o;
   logic [7:0] p4_oen;
   logic [7:0] p4_pu;

   // Thirteen bidirectional pins over three groups
   port_group #(.IMPL_MASK(`MASK_GRP1)) u_grp1 (
      .clk_i        (clk_i),
      .sys_rst_i    (sys_rst_i),
      .data_we_i    (wr_data1),
      .dir_we_i     (wr_dir1),
      .wdata_i      (dat_i[7:0]),
      .periph_oe_i  (periph1_oe_i),
      .periph_out_i (periph1_out_i),
      .pu_sel_i     (pu1),
      .pin_i        (grp1_pin_i),
      .pin_o        (p1_o),
      .pin_oe_n_o   (p1_oen),
      .pullup_o     (p1_pu),
      .data_rd_o    (rd1),
      .dir_o        (dir1)
   );

   port_group #(.IMPL_MASK(`MASK_GRP3)) u_grp3 (
      .clk_i        (clk_i),
      .sys_rst_i    (sys_rst_i),
      .data_we_i    (wr_data3),
      .dir_we_i     (wr_dir3),
      .wdata_i      (dat_i[7:0]),
      .periph_oe_i  (periph3_oe_i),
      .periph_out_i (periph3_out_i),
      .pu_sel_i     (pu3),
      .pin_i        (grp3_pin_i),
      .pin_o        (p3_o),
      .pin_oe_n_o   (p3_oen),
      .pullup_o     (p3_pu),
      .data_rd_o    (rd3),
      .dir_o        (dir3)
   );

   port_group #(.IMPL_MASK(`MASK_GRP4)) u_grp4 (
      .clk_i        (clk_i),
      .sys_rst_i    (sys_rst_i),
      .data_we_i    (wr_data4),
      .dir_we_i     (wr_dir4),
      .wdata_i      (dat_i[7:0]),
      .periph_oe_i  (periph4_oe_i & `MASK_GRP4),
      .periph_out_i (periph4_out_i),
      .pu_sel_i     (pu4),
      .pin_i        (grp4_pin_i),
      .pin_o        (p4_o),
      .pin_oe_n_o   (p4_oen),
      .pullup_o     (p4_pu),
      .data_rd_o    (rd4),
      .dir_o        (dir4)
   );

   // --------------------------------------------------------------
   // Input-only pins of group four
   // --------------------------------------------------------------
   logic [7:0] in4;

   // Shared pins read zero while their analog function owns them
   always_comb begin
      in4 = rd4;
      in4[`BIT_ANALOG_IN] = ~share_ff[`SC_ADC_USED]
                            & grp4_pin_i[`BIT_ANALOG_IN];
      in4[`BIT_OSC_IN_A]  = ~share_ff[`SC_OSC_USED]
                            & grp4_pin_i[`BIT_OSC_IN_A];
      in4[`BIT_OSC_IN_B]  = ~share_ff[`SC_OSC_USED]
                            & grp4_pin_i[`BIT_OSC_IN_B];
   end

   // --------------------------------------------------------------
   // Read mux and unmapped decode
   //   data 00/04/08, direction 0c/10/14, pull-up 18/1c,
   //   share control 20; every other offset answers with err
   //   and stores nothing, so a stray pointer cannot flip
   //   a pin into output mode
   // --------------------------------------------------------------
   always_comb begin
      hit       = 1'b1;
      nxt_rdata = 32'h0000_0000;
      case (adr_i)
         `OFS_DATA1:     nxt_rdata[7:0] = rd1;
         `OFS_DATA3:     nxt_rdata[7:0] = rd3;
         `OFS_DATA4:     nxt_rdata[7:0] = in4;
         `OFS_DIR1:      nxt_rdata[7:0] = dir1;
         `OFS_DIR3:      nxt_rdata[7:0] = dir3;
         `OFS_DIR4:      nxt_rdata[7:0] = dir4;
         `OFS_PULLUP_A:  nxt_rdata[1:0] = pu_a_ff;
         `OFS_PULLUP_B:  nxt_rdata[2:0] = pu_b_ff;
         `OFS_SHARE_CTL: nxt_rdata[1:0] = share_ff;
         default:        hit = 1'b0;
      endcase
   end

   // --------------------------------------------------------------
   // Bus answer: one wait state, ack or err for one cycle
   // --------------------------------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_ff <= gpio_port_pkg::BUS_IDLE;
         ack_o  <= 1'b0;
         err_o  <= 1'b0;
         dat_o  <= 32'h0000_0000;
      end else begin
         case (bus_ff)
            gpio_port_pkg::BUS_IDLE: begin
               ack_o <= req & hit;
               err_o <= req & ~hit;
               if (req) begin
                  bus_ff <= gpio_port_pkg::BUS_ACK;
                  dat_o  <= we_i ? 32'h0000_0000 : nxt_rdata;
               end
            end
            gpio_port_pkg::BUS_ACK: begin
               ack_o  <= 1'b0;
               err_o  <= 1'b0;
               bus_ff <= gpio_port_pkg::BUS_IDLE;
            end
            default: begin
               bus_ff <= gpio_port_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // Registered pin outputs; input-only pins never drive
   // --------------------------------------------------------------
   // Group one pins
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         grp1_pin_o      <= 8'h00;
         grp1_pin_oe_n_o <= 8'hff;
         grp1_pullup_o   <= 8'h00;
      end else begin
         grp1_pin_o      <= p1_o;
         grp1_pin_oe_n_o <= p1_oen;
         grp1_pullup_o   <= p1_pu;
      end
   end

   // Group three pins
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         grp3_pin_o      <= 8'h00;
         grp3_pin_oe_n_o <= 8'hff;
         grp3_pullup_o   <= 8'h00;
      end else begin
         grp3_pin_o      <= p3_o;
         grp3_pin_oe_n_o <= p3_oen;
         grp3_pullup_o   <= p3_pu;
      end
   end

   // Group four pins; the shared inputs stay undriven in any mode
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         grp4_pin_o      <= 8'h00;
         grp4_pin_oe_n_o <= 8'hff;
         grp4_pullup_o   <= 8'h00;
      end else begin
         grp4_pin_o      <= p4_o;
         grp4_pin_oe_n_o <= p4_oen | `MASK_IN4;
         grp4_pullup_o   <= p4_pu;
      end
   end

   // Shared-pin usage shown to the rest of the chip
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         adc_used_o <= 1'b1;
         osc_used_o <= 1'b1;
      end else begin
         adc_used_o <= share_ff[`SC_ADC_USED];
         osc_used_o <= share_ff[`SC_OSC_USED];
      end
   end

endmodule

/* File: include/gpio_port_defs.svh */
// Register offsets, field positions, reset values for the I/O port block.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_DATA1      6'h00
`define OFS_DATA3      6'h04
`define OFS_DATA4      6'h08
`define OFS_DIR1       6'h0c
`define OFS_DIR3       6'h10
`define OFS_DIR4       6'h14
`define OFS_PULLUP_A   6'h18
`define OFS_PULLUP_B   6'h1c
`define OFS_SHARE_CTL  6'h20

// ----------------------------------------------------------------------
// Implemented bit masks
// ----------------------------------------------------------------------
`define MASK_GRP1      8'hff
`define MASK_GRP3      8'hb8
`define MASK_GRP4      8'h20
`define MASK_IN4       8'hc4
`define BIT_ANALOG_IN  2
`define BIT_OSC_IN_A   6
`define BIT_OSC_IN_B   7

// ----------------------------------------------------------------------
// Pull-up fields: a (b0 grp1 low, b1 grp1 high), b (b0 grp3_3..5,
// b1 grp3_7, b2 grp4_5)
// ----------------------------------------------------------------------
`define PU_G1_LO       0
`define PU_G1_HI       1
`define PU_G3_345      0
`define PU_G3_7        1
`define PU_G4_5        2

// ----------------------------------------------------------------------
// Share control fields and reset values
// ----------------------------------------------------------------------
`define SC_ADC_USED    0
`define SC_OSC_USED    1
`define RST_DIR        8'h00
`define RST_DATA       8'h00
`define RST_PULLUP     3'h0
`define RST_SHARE      2'h3
`define WB_DW          32

`endif

/* File: include/gpio_port_pkg.sv */
// Types for the I/O port block.
// Assumes the defs header supplies all numeric constants.
package gpio_port_pkg;
   typedef logic [7:0] port_byte_t;
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;
endpackage
